/* File: common/eir_consts.vh */
// register offsets, field positions and reset values of the request logic
`ifndef EIR_CONSTS_VH
`define EIR_CONSTS_VH

// byte offsets of the wishbone register map
`define EIR_OFF_EN      8'h00
`define EIR_OFF_XEN     8'h04
`define EIR_OFF_PRI     8'h08
`define EIR_OFF_XPRI    8'h0C
`define EIR_OFF_TCTL    8'h10
`define EIR_OFF_XFLAG   8'h14
`define EIR_OFF_XCTL    8'h18
`define EIR_OFF_SETUP   8'h1C
`define EIR_OFF_PACFG   8'h20
`define EIR_OFF_PECFG   8'h24
`define EIR_OFF_PEOE    8'h28
`define EIR_OFF_STAT    8'h2C
`define EIR_OFF_MASK    8'h30
`define EIR_OFF_STATE   8'h34

// field positions
`define EIR_EN_ZERO     0
`define EIR_EN_ONE      2
`define EIR_EN_GLOBAL   7
`define EIR_EX_FOUR     2
`define EIR_EX_FIVE     3
`define EIR_EX_SIX      4
`define EIR_TC_MODE0    0
`define EIR_TC_FLAG0    1
`define EIR_TC_MODE1    2
`define EIR_TC_FLAG1    3
`define EIR_XF_FOUR     6
`define EIR_XF_FIVE     7
`define EIR_XC_SIX      3
`define EIR_SETUP_SRC4  1
`define EIR_PA_ZERO     0
`define EIR_PA_ONE      1
`define EIR_PE_FIVE     5

// natural priority numbers, lowest wins among equals
`define EIR_NAT_ZERO    4'h1
`define EIR_NAT_ONE     4'h3
`define EIR_NAT_FOUR    4'hA
`define EIR_NAT_FIVE    4'hB
`define EIR_NAT_SIX     4'hC

// reset values
`define EIR_RST_BYTE    8'h00
`define EIR_RST_SRC     5'h00

`endif

/* File: rtl/eir_src_det.v */
// polarity and level or edge detection for one interrupt input
`timescale 1ns/1ns
module eir_src_det #(
	parameter ACTIVE_LOW = 1
) (
	// clock and reset
	input  wire MCLK,
	input  wire NRST,
	// source
	input  wire raw,
	input  wire edge_mode,
	// result
	output wire active,
	output wire hit
);
	reg prev_active;

	// the raw pin is inverted for active-low inputs
	assign active = ACTIVE_LOW ? ~raw : raw;

	// previous sample starts inactive so an input already active after reset makes an edge
	always @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			prev_active <= 1'b0;
		end else begin
			prev_active <= active;
		end
	end

	// edge mode, active-low: falling pin edge; active-high: rising pin edge; level mode: the active level
	assign hit = edge_mode ? (active & ~prev_active) : active;
endmodule // eir_src_det

/* File: rtl/eir_top.v */
// external interrupt request logic with wishbone register access
//
// Local design decisions: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ns
`include "eir_consts.vh"

module eir_top #(
	parameter HAS_PIN_FIVE = 1
) (
	// clock and reset
	input  wire        MCLK,
	input  wire        NRST,
	// wishbone slave
	input  wire        WB_CYC_I,
	input  wire        WB_STB_I,
	input  wire        WB_WE_I,
	input  wire [7:0]  WB_ADR_I,
	input  wire [3:0]  WB_SEL_I,
	input  wire [31:0] WB_DAT_I,
	output reg  [31:0] WB_DAT_O,
	output reg         WB_ACK_O,
	// interrupt pins
	input  wire        PORT_A_PIN_ZERO,
	input  wire        PORT_A_PIN_ONE,
	input  wire        EXT_IRQ_FOUR_PIN,
	input  wire        EXT_IRQ_FIVE_PIN,
	input  wire        PORT_E_PIN_FIVE,
	output reg         PORT_E_PIN_FIVE_OE_N,
	// internal sources for irq four
	input  wire        FIFO_IRQ,
	input  wire        WAVE_IRQ,
	// core side
	output reg         IRQ_REQ,
	output reg  [3:0]  IRQ_ID,
	output reg         IRQ_HIGH,
	input  wire        IRQ_ACK,
	// summary interrupt
	output reg         IRQ
);
	reg  [7:0] irq_enable_reg;
	reg  [7:0] extended_irq_enable_reg;
	reg  [7:0] irq_priority_reg;
	reg  [7:0] extended_irq_priority_reg;
	reg  [7:0] timer_control_reg;
	reg  [7:0] external_flag_reg;
	reg  [7:0] extended_irq_control_reg;
	reg  [7:0] irq_setup_reg;
	reg  [7:0] port_a_config_reg;
	reg  [7:0] port_e_config_reg;
	reg  [7:0] port_e_output_enable;
	reg  [4:0] irq_status;
	reg  [4:0] irq_mask;
	reg  [7:0] next_rdata;

	wire       bus_req;
	wire       wr_lane;
	wire [7:0] wdat;
	wire [7:0] word_adr;
	wire       global_irq_enable;
	wire       raw_zero;
	wire       raw_one;
	wire       raw_four;
	wire       raw_five;
	wire       raw_six;
	wire       act_zero;
	wire       act_one;
	wire       hit_zero;
	wire       hit_one;
	wire       hit_four;
	wire       hit_five;
	wire       hit_six;
	wire [4:0] events;
	wire [4:0] flags;
	wire [4:0] enables;
	wire [4:0] prio;
	wire [4:0] pending;
	wire [4:0] pend_high;
	wire [2:0] win;
	wire       edge0;
	wire       edge1;

	// lowest set index of a five-bit vector, 3'd7 when empty
	function [2:0] first_set;
		input [4:0] v;
		begin
			if (v[0]) begin
				first_set = 3'd0;
			end else if (v[1]) begin
				first_set = 3'd1;
			end else if (v[2]) begin
				first_set = 3'd2;
			end else if (v[3]) begin
				first_set = 3'd3;
			end else if (v[4]) begin
				first_set = 3'd4;
			end else begin
				first_set = 3'd7;
			end
		end
	endfunction

	// natural priority number of a source index
	function [3:0] natural_of;
		input [2:0] idx;
		begin
			case (idx)
				3'd0: natural_of = `EIR_NAT_ZERO;
				3'd1: natural_of = `EIR_NAT_ONE;
				3'd2: natural_of = `EIR_NAT_FOUR;
				3'd3: natural_of = `EIR_NAT_FIVE;
				3'd4: natural_of = `EIR_NAT_SIX;
				default: natural_of = 4'h0;
			endcase
		end
	endfunction

	// a write hits a register when lane 0 is selected
	function wr_hit;
		input [7:0] off;
		begin
			wr_hit = wr_lane & (word_adr == off);
		end
	endfunction

	assign bus_req  = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
	assign wr_lane  = bus_req & WB_WE_I & WB_SEL_I[0];
	assign wdat     = WB_DAT_I[7:0];
	assign word_adr = {WB_ADR_I[7:2], 2'b00};
	assign global_irq_enable = irq_enable_reg[`EIR_EN_GLOBAL];

	// pin routing; an unrouted input sits at its inactive level
	assign raw_zero = port_a_config_reg[`EIR_PA_ZERO] ?
		PORT_A_PIN_ZERO : 1'b1;
	assign raw_one  = port_a_config_reg[`EIR_PA_ONE] ?
		PORT_A_PIN_ONE : 1'b1;
	assign raw_four = irq_setup_reg[`EIR_SETUP_SRC4] ?
		(FIFO_IRQ | WAVE_IRQ) : EXT_IRQ_FOUR_PIN;
	// small packages lack the pin, so it is held inactive
	assign raw_five = (HAS_PIN_FIVE != 0) ? EXT_IRQ_FIVE_PIN : 1'b1;
	assign raw_six  = (port_e_config_reg[`EIR_PE_FIVE] &
		~port_e_output_enable[`EIR_PE_FIVE]) ? PORT_E_PIN_FIVE : 1'b0;

	assign edge0 = timer_control_reg[`EIR_TC_MODE0];
	assign edge1 = timer_control_reg[`EIR_TC_MODE1];

	eir_src_det #(.ACTIVE_LOW(1)) u_zero (
		.MCLK(MCLK), .NRST(NRST), .raw(raw_zero), .edge_mode(edge0),
		.active(act_zero), .hit(hit_zero));
	eir_src_det #(.ACTIVE_LOW(1)) u_one (
		.MCLK(MCLK), .NRST(NRST), .raw(raw_one), .edge_mode(edge1),
		.active(act_one), .hit(hit_one));
	eir_src_det #(.ACTIVE_LOW(0)) u_four (
		.MCLK(MCLK), .NRST(NRST), .raw(raw_four), .edge_mode(1'b1),
		.active(), .hit(hit_four));
	eir_src_det #(.ACTIVE_LOW(1)) u_five (
		.MCLK(MCLK), .NRST(NRST), .raw(raw_five), .edge_mode(1'b1),
		.active(), .hit(hit_five));
	eir_src_det #(.ACTIVE_LOW(0)) u_six (
		.MCLK(MCLK), .NRST(NRST), .raw(raw_six), .edge_mode(1'b1),
		.active(), .hit(hit_six));

	assign events = {hit_six, hit_five, hit_four, hit_one, hit_zero};
	assign flags = {extended_irq_control_reg[`EIR_XC_SIX],
		external_flag_reg[`EIR_XF_FIVE], external_flag_reg[`EIR_XF_FOUR],
		timer_control_reg[`EIR_TC_FLAG1], timer_control_reg[`EIR_TC_FLAG0]};
	assign enables = {extended_irq_enable_reg[`EIR_EX_SIX],
		extended_irq_enable_reg[`EIR_EX_FIVE],
		extended_irq_enable_reg[`EIR_EX_FOUR],
		irq_enable_reg[`EIR_EN_ONE], irq_enable_reg[`EIR_EN_ZERO]};
	assign prio = {extended_irq_priority_reg[`EIR_EX_SIX],
		extended_irq_priority_reg[`EIR_EX_FIVE],
		extended_irq_priority_reg[`EIR_EX_FOUR],
		irq_priority_reg[`EIR_EN_ONE], irq_priority_reg[`EIR_EN_ZERO]};

	// high level first, then lowest natural number
	assign pending   = flags & enables & {5{global_irq_enable}};
	assign pend_high = pending & prio;
	assign win = (|pend_high) ? first_set(pend_high) : first_set(pending);

	// wishbone: one wait state, ack for one cycle, unmapped reads zero
	always @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h0000_0000;
		end else begin
			WB_ACK_O <= bus_req;
			WB_DAT_O <= {24'h00_0000, next_rdata};
		end
	end

	always @* begin
		case (word_adr)
			`EIR_OFF_EN:    next_rdata = irq_enable_reg;
			`EIR_OFF_XEN:   next_rdata = extended_irq_enable_reg;
			`EIR_OFF_PRI:   next_rdata = irq_priority_reg;
			`EIR_OFF_XPRI:  next_rdata = extended_irq_priority_reg;
			`EIR_OFF_TCTL:  next_rdata = timer_control_reg;
			`EIR_OFF_XFLAG: next_rdata = external_flag_reg;
			`EIR_OFF_XCTL:  next_rdata = extended_irq_control_reg;
			`EIR_OFF_SETUP: next_rdata = irq_setup_reg;
			`EIR_OFF_PACFG: next_rdata = port_a_config_reg;
			`EIR_OFF_PECFG: next_rdata = port_e_config_reg;
			`EIR_OFF_PEOE:  next_rdata = port_e_output_enable;
			`EIR_OFF_STAT:  next_rdata = {3'b000, irq_status};
			`EIR_OFF_MASK:  next_rdata = {3'b000, irq_mask};
			`EIR_OFF_STATE: next_rdata = {IRQ_REQ, IRQ_HIGH, 2'b00, IRQ_ID};
			default:        next_rdata = 8'h00;
		endcase
	end

	// plain control registers, only implemented bits are kept
	always @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			irq_enable_reg            <= `EIR_RST_BYTE;
			extended_irq_enable_reg   <= `EIR_RST_BYTE;
			irq_priority_reg          <= `EIR_RST_BYTE;
			extended_irq_priority_reg <= `EIR_RST_BYTE;
			irq_setup_reg             <= `EIR_RST_BYTE;
			port_a_config_reg         <= `EIR_RST_BYTE;
			port_e_config_reg         <= `EIR_RST_BYTE;
			port_e_output_enable      <= `EIR_RST_BYTE;
			irq_mask                  <= `EIR_RST_SRC;
		end else begin
			if (wr_hit(`EIR_OFF_EN)) begin
				irq_enable_reg <= wdat & 8'h85;
			end
			if (wr_hit(`EIR_OFF_XEN)) begin
				extended_irq_enable_reg <= wdat & 8'h1C;
			end
			if (wr_hit(`EIR_OFF_PRI)) begin
				irq_priority_reg <= wdat & 8'h05;
			end
			if (wr_hit(`EIR_OFF_XPRI)) begin
				extended_irq_priority_reg <= wdat & 8'h1C;
			end
			if (wr_hit(`EIR_OFF_SETUP)) begin
				irq_setup_reg <= wdat & 8'h02;
			end
			if (wr_hit(`EIR_OFF_PACFG)) begin
				port_a_config_reg <= wdat & 8'h03;
			end
			if (wr_hit(`EIR_OFF_PECFG)) begin
				port_e_config_reg <= wdat & 8'h20;
			end
			if (wr_hit(`EIR_OFF_PEOE)) begin
				port_e_output_enable <= wdat & 8'h20;
			end
			if (wr_hit(`EIR_OFF_MASK)) begin
				irq_mask <= wdat[4:0];
			end
		end
	end

	// request flags: a hardware set wins over a software write of zero
	always @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			timer_control_reg        <= `EIR_RST_BYTE;
			external_flag_reg        <= `EIR_RST_BYTE;
			extended_irq_control_reg <= `EIR_RST_BYTE;
		end else begin
			if (wr_hit(`EIR_OFF_TCTL)) begin
				timer_control_reg[`EIR_TC_MODE0] <= wdat[`EIR_TC_MODE0];
				timer_control_reg[`EIR_TC_MODE1] <= wdat[`EIR_TC_MODE1];
			end
			// level mode: the flag simply follows the pin
			if (!edge0) begin
				timer_control_reg[`EIR_TC_FLAG0] <= act_zero;
			end else if (hit_zero) begin
				timer_control_reg[`EIR_TC_FLAG0] <= 1'b1;
			end else if (wr_hit(`EIR_OFF_TCTL)) begin
				timer_control_reg[`EIR_TC_FLAG0] <= wdat[`EIR_TC_FLAG0];
			end else if (IRQ_ACK && IRQ_ID == `EIR_NAT_ZERO) begin
				timer_control_reg[`EIR_TC_FLAG0] <= 1'b0;
			end
			if (!edge1) begin
				timer_control_reg[`EIR_TC_FLAG1] <= act_one;
			end else if (hit_one) begin
				timer_control_reg[`EIR_TC_FLAG1] <= 1'b1;
			end else if (wr_hit(`EIR_OFF_TCTL)) begin
				timer_control_reg[`EIR_TC_FLAG1] <= wdat[`EIR_TC_FLAG1];
			end else if (IRQ_ACK && IRQ_ID == `EIR_NAT_ONE) begin
				timer_control_reg[`EIR_TC_FLAG1] <= 1'b0;
			end
			if (hit_four) begin
				external_flag_reg[`EIR_XF_FOUR] <= 1'b1;
			end else if (wr_hit(`EIR_OFF_XFLAG)) begin
				external_flag_reg[`EIR_XF_FOUR] <= wdat[`EIR_XF_FOUR];
			end
			if (hit_five) begin
				external_flag_reg[`EIR_XF_FIVE] <= 1'b1;
			end else if (wr_hit(`EIR_OFF_XFLAG)) begin
				external_flag_reg[`EIR_XF_FIVE] <= wdat[`EIR_XF_FIVE];
			end
			if (hit_six) begin
				extended_irq_control_reg[`EIR_XC_SIX] <= 1'b1;
			end else if (wr_hit(`EIR_OFF_XCTL)) begin
				extended_irq_control_reg[`EIR_XC_SIX] <= wdat[`EIR_XC_SIX];
			end
		end
	end

	// sticky event status, write one to clear, set wins
	always @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			irq_status <= `EIR_RST_SRC;
		end else if (wr_hit(`EIR_OFF_STAT)) begin
			irq_status <= (irq_status & ~wdat[4:0]) | events;
		end else begin
			irq_status <= irq_status | events;
		end
	end

	// registered outputs toward the core and the pad
	always @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			IRQ_REQ              <= 1'b0;
			IRQ_ID               <= 4'h0;
			IRQ_HIGH             <= 1'b0;
			IRQ                  <= 1'b0;
			PORT_E_PIN_FIVE_OE_N <= 1'b1;
		end else begin
			IRQ_REQ  <= |pending;
			IRQ_ID   <= natural_of(win);
			IRQ_HIGH <= |pend_high;
			IRQ      <= |(irq_status & irq_mask);
			// the pin stays an input unless software enables its driver
			PORT_E_PIN_FIVE_OE_N <= ~port_e_output_enable[`EIR_PE_FIVE];
		end
	end
endmodule // eir_top

/* File: test/eir_top_assertions.sv */
// concurrent checks on the ports of the request logic
`timescale 1ns/1ns
module eir_chk (
	// clock and reset
	input wire        MCLK,
	input wire        NRST,
	// wishbone
	input wire        WB_CYC_I,
	input wire        WB_STB_I,
	input wire        WB_WE_I,
	input wire [7:0]  WB_ADR_I,
	input wire [3:0]  WB_SEL_I,
	input wire [31:0] WB_DAT_O,
	input wire        WB_ACK_O,
	// pins and core side
	input wire        PORT_E_PIN_FIVE_OE_N,
	input wire        IRQ_REQ,
	input wire [3:0]  IRQ_ID,
	input wire        IRQ_HIGH,
	input wire        IRQ
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (!NRST);
	wire take = WB_CYC_I && WB_STB_I && !WB_ACK_O;
	wire rd = take && !WB_WE_I;
	// oe write lands on the taking edge, output may lag one more
	wire oe_wr = take && WB_WE_I && WB_ADR_I[7:2] == 6'h0A && WB_SEL_I[0];

	a_ack_answer: assert property (take |=> WB_ACK_O)
		else $error("ack missing one cycle after request");
	a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack longer than one cycle");
	a_ack_cause: assert property ($rose(WB_ACK_O) |-> $past(take))
		else $error("ack without request");
	a_dat_upper: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h00_0000)
		else $error("upper read data not zero");
	a_unmapped_zero: assert property (
		(rd && WB_ADR_I[7:2] == 6'h0F) |=> WB_DAT_O[7:0] == 8'h00)
		else $error("unmapped read not zero");
	a_state_read: assert property (
		(rd && WB_ADR_I[7:2] == 6'h0D) |=> WB_DAT_O[7:0] ==
		{$past(IRQ_REQ), $past(IRQ_HIGH), 2'b00, $past(IRQ_ID)})
		else $error("state read differs from core outputs");
	a_oe_write: assert property (
		$changed(PORT_E_PIN_FIVE_OE_N) |-> $past(oe_wr) || $past(oe_wr, 2))
		else $error("output enable changed without write");
	a_id_valid: assert property (
		IRQ_REQ |-> IRQ_ID inside {4'h1, 4'h3, 4'hA, 4'hB, 4'hC})
		else $error("request with unknown source number");

	c_six: cover property (IRQ_REQ && IRQ_ID == 4'hC);
	c_irq: cover property ($rose(IRQ));
	c_high: cover property (IRQ_REQ && IRQ_HIGH);
endmodule // eir_chk

/* File: test/eir_pin_src.sv */
// model of the external sources driving the interrupt pins
`timescale 1ns/1ns
module eir_pin_src (
	// clock
	input wire         MCLK,
	// zero, one, four, five, six, fifo, wave
	output logic [6:0] pin
);
	// active-low sources rest high
	localparam logic [6:0] IDLE = 7'h0B;
	initial pin = IDLE;
	// two-cycle active pulse: exactly one edge each way
	task automatic pulse(input int k);
		@(posedge MCLK);
		pin[k] <= ~IDLE[k];
		repeat (2) @(posedge MCLK);
		pin[k] <= IDLE[k];
	endtask
	task automatic hold(input int k, input bit on);
		@(posedge MCLK);
		pin[k] <= on ? ~IDLE[k] : IDLE[k];
	endtask
endmodule // eir_pin_src

/* File: test/tb_top.sv */
// self-checking bench for the external interrupt request logic
`timescale 1ns/1ns
module tb_top;
	logic        mclk = 1'b0;
	logic        nrst = 1'b0;
	logic        cyc = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0000_0000;
	logic        irq_ack = 1'b0;
	logic [3:0]  sel = 4'hF;
	logic [3:0]  wsel = 4'hF;
	logic [31:0] rdat;
	logic        ack, oe_n, req, high, irq;
	logic [3:0]  id;
	logic [6:0]  pin;
	logic [7:0]  rd;
	int          num_errors = 0;
	int          comparisons = 0;
	int          cycles = 0;
	logic [7:0] foff [7] = '{8'h10, 8'h10, 8'h14, 8'h14, 8'h18, 8'h14, 8'h14};
	logic [7:0] fset [7] = '{8'h07, 8'h0D, 8'h40, 8'h80, 8'h08, 8'h40, 8'h40};
	logic [7:0] sbit [7] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h04, 8'h04};
	logic [3:0] nat [7] = '{4'h1, 4'h3, 4'hA, 4'hB, 4'hC, 4'hA, 4'hA};

	always #4 mclk = ~mclk;

	eir_pin_src src (.MCLK(mclk), .pin(pin));
	eir_top dut (
		.MCLK(mclk), .NRST(nrst), .WB_CYC_I(cyc), .WB_STB_I(cyc),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
		.WB_DAT_O(rdat), .WB_ACK_O(ack),
		.PORT_A_PIN_ZERO(pin[0]), .PORT_A_PIN_ONE(pin[1]),
		.EXT_IRQ_FOUR_PIN(pin[2]), .EXT_IRQ_FIVE_PIN(pin[3]),
		.PORT_E_PIN_FIVE(pin[4]), .PORT_E_PIN_FIVE_OE_N(oe_n),
		.FIFO_IRQ(pin[5]), .WAVE_IRQ(pin[6]), .IRQ_REQ(req), .IRQ_ID(id),
		.IRQ_HIGH(high), .IRQ_ACK(irq_ack), .IRQ(irq));

	task automatic finish_test;
		if (num_errors == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] got,
		input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %s exp %h got %h", nm, exp, got);
		end
	endtask

	// classic cycle: request held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		sel <= wsel;
		wdat <= {24'h00_0000, d};
		// only the bench timeout ends a wait for ack
		do
			@(posedge mclk);
		while (ack !== 1'b1);
		rd = rdat[7:0];
		cyc <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] e, string nm);
		wb(1'b0, a, 8'h00);
		chk(nm, rd, e);
	endtask

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			finish_test;
		end
	end

	initial begin
		repeat (3) @(posedge mclk);
		nrst <= 1'b1;
		rchk(8'h00, 8'h00, "enable reset");
		rchk(8'h3C, 8'h00, "unmapped");
		rchk(8'h34, 8'h00, "state reset");
		chk("oe_n reset", {7'h00, oe_n}, 8'h01);
		// a write without byte lane 0 is dropped
		wsel = 4'hE;
		wb(1'b1, 8'h30, 8'h1F);
		wsel = 4'hF;
		rchk(8'h30, 8'h00, "no lane");
		wb(1'b1, 8'h28, 8'h20);
		@(posedge mclk);
		chk("oe_n driven", {7'h00, oe_n}, 8'h00);
		wb(1'b1, 8'h28, 8'h00);
		wb(1'b1, 8'h20, 8'h03);
		wb(1'b1, 8'h10, 8'h05);
		wb(1'b1, 8'h00, 8'h85);
		wb(1'b1, 8'h04, 8'h1C);
		wb(1'b1, 8'h24, 8'h20);
		wb(1'b1, 8'h30, 8'h1F);
		// every source in turn; fifo and wave feed irq four
		for (int k = 0; k < 7; k++) begin
			if (k == 5)
				wb(1'b1, 8'h1C, 8'h02);
			src.pulse(k);
			repeat (4) @(posedge mclk);
			rchk(foff[k], fset[k], "flag");
			rchk(8'h2C, sbit[k], "status");
			rchk(8'h34, {4'h8, nat[k]}, "state");
			chk("irq", {7'h00, irq}, 8'h01);
			if (k < 2) begin
				@(posedge mclk);
				irq_ack <= 1'b1;
				@(posedge mclk);
				irq_ack <= 1'b0;
			end else
				wb(1'b1, foff[k], 8'h00);
			wb(1'b1, 8'h2C, sbit[k]);
			rchk(foff[k], k < 2 ? 8'h05 : 8'h00, "cleared");
			chk("irq clear", {7'h00, irq}, 8'h00);
		end
		// internal source selected: pin four is ignored
		src.pulse(2);
		repeat (4) @(posedge mclk);
		rchk(8'h14, 8'h00, "pin four off");
		wb(1'b1, 8'h1C, 8'h00);
		// level mode follows the pin
		wb(1'b1, 8'h10, 8'h00);
		src.hold(0, 1'b1);
		repeat (4) @(posedge mclk);
		rchk(8'h10, 8'h02, "level on");
		src.hold(0, 1'b0);
		repeat (4) @(posedge mclk);
		rchk(8'h10, 8'h00, "level off");
		// unrouted pin one stays silent
		wb(1'b1, 8'h20, 8'h00);
		wb(1'b1, 8'h10, 8'h05);
		src.pulse(1);
		repeat (4) @(posedge mclk);
		rchk(8'h10, 8'h05, "unrouted");
		wb(1'b1, 8'h20, 8'h03);
		wb(1'b1, 8'h2C, 8'h1F);
		// global off and mask off hold back six
		wb(1'b1, 8'h30, 8'h00);
		wb(1'b1, 8'h00, 8'h05);
		src.pulse(4);
		repeat (4) @(posedge mclk);
		rchk(8'h2C, 8'h10, "status six");
		chk("req global", {7'h00, req}, 8'h00);
		chk("irq masked", {7'h00, irq}, 8'h00);
		wb(1'b1, 8'h00, 8'h85);
		rchk(8'h34, 8'h8C, "six alone");
		// zero joins: natural order, then priority groups
		src.pulse(0);
		repeat (4) @(posedge mclk);
		rchk(8'h34, 8'h81, "natural");
		wb(1'b1, 8'h0C, 8'h10);
		rchk(8'h34, 8'hCC, "six high");
		wb(1'b1, 8'h08, 8'h01);
		rchk(8'h34, 8'hC1, "both high");
		finish_test;
	end
endmodule // tb_top

bind eir_top eir_chk u_chk (
	.MCLK(MCLK), .NRST(NRST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
	.WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
	.WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
	.PORT_E_PIN_FIVE_OE_N(PORT_E_PIN_FIVE_OE_N), .IRQ_REQ(IRQ_REQ),
	.IRQ_ID(IRQ_ID), .IRQ_HIGH(IRQ_HIGH), .IRQ(IRQ));
